// ### rtl/ctc_control_timer.sv
// Control timer counter core with APB register slave
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
module ctc_control_timer
  import ctc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic count_event_in0,
  input wire logic nr_fault_in,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_CH-1:0] wave_out,
  output logic ovf_event_out,
  output logic dma_req_out
);

  ctc_state_s st;
  ctc_state_s n;

  logic [CNT_W-1:0] top;
  logic [PSC_W-1:0] lim;
  logic dir;
  logic at_zero;
  logic at_top;
  logic evmode;
  logic running;
  logic presc_tick;
  logic ev_tick;
  logic tick;
  logic gclk_sync;
  logic wrap_go;
  logic acc;
  logic addr_ok;
  logic wr_go;
  logic cnt_wr;
  logic ctrl_wr;
  logic [DATA_W-1:0] rd;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    n = st;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.ovf_evt = 1'b0;
    n.dma_req = 1'b0;
    rd = '0;

    // Event and fault inputs are asynchronous to pclk
    n.ev_s1 = count_event_in0;
    n.ev_s2 = st.ev_s1;
    n.ev_s3 = st.ev_s2;
    n.flt_s1 = nr_fault_in;
    n.flt_s2 = st.flt_s1;

    top = (st.wave[B_WG +: 3] == WG_MFRQ) ? st.cc[0] : st.period_reg;
    dir = st.control_b_reg[B_DIR];
    at_zero = (st.count == '0);
    at_top = (st.count == top);
    evmode = st.event_control[B_CNTEV];
    lim = evmode ? '0 : ctc_div_limit(st.control_a_reg[B_PSC +: 3]);
    running = (st.run == CTC_RUN);
    presc_tick = running && !evmode && (st.presc == lim);
    ev_tick = st.ev_s2 & ~st.ev_s3;
    tick = presc_tick | (running & evmode & ev_tick);
    // Clock-synchronous wrap skips the wait for the next prescaled tick
    gclk_sync = (st.control_a_reg[B_PSYNC +: 2] == PSYNC_GCLK) && (lim != '0);
    wrap_go = running && (dir ? at_zero : at_top) && (gclk_sync || tick);

    if (running) begin
      if (presc_tick || (wrap_go && gclk_sync)) begin
        n.presc = '0;
      end else if (!evmode) begin
        n.presc = st.presc + 1'b1;
      end
    end

    if (wrap_go) begin
      n.count = dir ? top : '0;
      n.wrap_flag = 1'b1;
      n.dma_req = 1'b1;
      n.ovf_evt = st.event_control[B_OVFEO];
      if (st.period_buffer_reg_v) begin
        n.period_reg = st.period_buffer_reg;
        n.period_buffer_reg_v = 1'b0;
      end
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (st.ccb_v[ch]) begin
          n.cc[ch] = st.ccb[ch];
          n.ccb_v[ch] = 1'b0;
        end
      end
      if (st.control_b_reg[B_SINGLE_RUN_BIT]) begin
        n.run = CTC_HALT;
      end
    end else if (tick) begin
      n.count = dir ? st.count - 1'b1 : st.count + 1'b1;
    end

    for (int ch = 0; ch < NUM_CH; ch++) begin
      n.wave_q[ch] = (st.count < st.cc[ch]);
    end

    // APB: one wait state, answer registered
    acc = psel && penable;
    addr_ok = (paddr[1:0] == 2'h0) && (paddr <= OFF_LAST);
    wr_go = acc && pwrite && st.pready && addr_ok;
    cnt_wr = wr_go && (paddr == OFF_COUNT);
    ctrl_wr = wr_go && (paddr == OFF_CONTROL_A_REG);

    case (paddr)
      OFF_CONTROL_A_REG: rd = st.control_a_reg;
      OFF_CONTROL_B_REG: rd = st.control_b_reg;
      OFF_EVENT_CONTROL: rd = st.event_control;
      OFF_FAULTA: rd = st.fault_a;
      OFF_FAULTB: rd = st.fault_b;
      OFF_WAVE_EXTENSION_CONTROL: rd = st.wave_extension_control;
      OFF_DRIVER_CONTROL: rd = st.driver_control;
      OFF_DEBUG_CONTROL: rd = st.debug_control;
      OFF_WAVE: rd = st.wave;
      OFF_IRQ_FLAG_REG: rd[B_WRAP] = st.wrap_flag;
      OFF_STATUS: begin
        rd[B_PERBV] = st.period_buffer_reg_v;
        rd[B_CCBV +: NUM_CH] = st.ccb_v;
        rd[B_HALT] = (st.run == CTC_HALT);
      end
      OFF_COUNT: rd[CNT_W-1:0] = st.count;
      OFF_PER: rd[CNT_W-1:0] = st.period_reg;
      OFF_PERIOD_BUFFER_REG: rd[CNT_W-1:0] = st.period_buffer_reg;
      default: begin
        if (addr_ok && paddr >= OFF_CCB0) begin
          rd[CNT_W-1:0] = st.ccb[ctc_ch(paddr, OFF_CCB0)];
        end else if (addr_ok && paddr >= OFF_CC0) begin
          rd[CNT_W-1:0] = st.cc[ctc_ch(paddr, OFF_CC0)];
        end
      end
    endcase

    if (acc && !st.pready) begin
      n.pready = 1'b1;
      n.pslverr = !addr_ok;
      n.prdata = rd;
    end

    if (wr_go) begin
      case (paddr)
        OFF_CONTROL_A_REG: begin
          // Access that clears enable sees protection too, since enable is still set
          if (!st.control_a_reg[B_EN]) begin
            n.control_a_reg = pwdata & CONTROL_A_REG_WMASK;
          end else begin
            n.control_a_reg = (st.control_a_reg & ~CONTROL_A_REG_FREE) | (pwdata & CONTROL_A_REG_FREE);
          end
          n.control_a_reg[B_SOFT_RESET_BIT] = 1'b0;
          if (pwdata[B_EN] && !st.control_a_reg[B_EN]) begin
            n.run = CTC_RUN;
            n.presc = '0;
            n.touched = 1'b0;
            if (!st.touched) begin
              n.count = dir ? top : '0;
            end
          end else if (!pwdata[B_EN] && st.control_a_reg[B_EN]) begin
            n.run = CTC_OFF;
            n.touched = (st.count != '0);
          end
        end
        OFF_CONTROL_B_REG: n.control_b_reg = pwdata & CONTROL_B_REG_WMASK;
        OFF_EVENT_CONTROL: begin
          if (!st.control_a_reg[B_EN]) begin
            n.event_control = pwdata & EVENT_CONTROL_WMASK;
          end
        end
        OFF_FAULTA: begin
          if (!st.control_a_reg[B_EN]) begin
            n.fault_a = pwdata;
          end
        end
        OFF_FAULTB: begin
          if (!st.control_a_reg[B_EN]) begin
            n.fault_b = pwdata;
          end
        end
        OFF_WAVE_EXTENSION_CONTROL: begin
          if (!st.control_a_reg[B_EN]) begin
            n.wave_extension_control = pwdata;
          end
        end
        OFF_DRIVER_CONTROL: begin
          if (!st.control_a_reg[B_EN]) begin
            n.driver_control = pwdata & DRIVER_CONTROL_WMASK;
          end
        end
        OFF_DEBUG_CONTROL: n.debug_control = pwdata & DBG_WMASK;
        OFF_WAVE: n.wave = pwdata & WAVE_WMASK;
        OFF_IRQ_FLAG_REG: begin
          // A wrap in the clearing cycle keeps the flag
          if (pwdata[B_WRAP] && !wrap_go) begin
            n.wrap_flag = 1'b0;
          end
        end
        OFF_COUNT: begin
          n.count = pwdata[CNT_W-1:0];
          n.touched = 1'b1;
        end
        OFF_PER: n.period_reg = pwdata[CNT_W-1:0];
        OFF_PERIOD_BUFFER_REG: begin
          n.period_buffer_reg = pwdata[CNT_W-1:0];
          n.period_buffer_reg_v = 1'b1;
        end
        default: begin
          if (paddr >= OFF_CCB0) begin
            n.ccb[ctc_ch(paddr, OFF_CCB0)] = pwdata[CNT_W-1:0];
            n.ccb_v[ctc_ch(paddr, OFF_CCB0)] = 1'b1;
          end else if (paddr >= OFF_CC0) begin
            n.cc[ctc_ch(paddr, OFF_CC0)] = pwdata[CNT_W-1:0];
          end
        end
      endcase
    end

    // Soft reset wins over everything; debug control survives it
    if (ctrl_wr && pwdata[B_SOFT_RESET_BIT]) begin
      n = CTC_RST;
      n.debug_control = st.debug_control;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= CTC_RST;
    end else begin
      st <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign ovf_event_out = st.ovf_evt;
  assign dma_req_out = st.dma_req;

  // Unfiltered fault path bypasses every flop so a stopped clock cannot delay it
  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (st.driver_control[B_NRE + ch] &&
          (st.driver_control[B_NRFILT] ? st.flt_s2 : nr_fault_in)) begin
        wave_out[ch] = st.driver_control[B_NRV + ch];
      end else begin
        wave_out[ch] = st.wave_q[ch];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  up_wrap_zero_a: assert property ((wrap_go && !dir && !wr_go) |=>
                                   (st.count == '0 && st.wrap_flag))
    else $error("up wrap did not clear counter and set flag");

  down_reload_a: assert property ((wrap_go && dir && !wr_go) |=>
                                  (st.count == $past(top) && st.wrap_flag))
    else $error("down wrap did not reload ceiling");

  flag_set_wins_a: assert property ((wrap_go && wr_go && paddr == OFF_IRQ_FLAG_REG)
                                    |=> st.wrap_flag ##1 st.wrap_flag)
    else $error("wrap flag lost against clear");

  protect_hold_a: assert property ((wr_go && paddr == OFF_EVENT_CONTROL &&
                                    st.control_a_reg[B_EN]) |=> $stable(st.event_control))
    else $error("protected register changed while enabled");

  single_run_a: assert property ((wrap_go && st.control_b_reg[B_SINGLE_RUN_BIT] && !ctrl_wr)
                                 |=> (st.run == CTC_HALT) ##1 $stable(st.count))
    else $error("single run did not stop counter");

  count_write_a: assert property (cnt_wr |=>
                                  (st.count == $past(pwdata[CNT_W-1:0])))
    else $error("counter write lost");

  buffer_valid_a: assert property ((wr_go && paddr == OFF_PERIOD_BUFFER_REG && !pwdata[B_SOFT_RESET_BIT])
                                   |=> st.period_buffer_reg_v)
    else $error("period buffer valid not set");

  soft_reset_a: assert property ((ctrl_wr && pwdata[B_SOFT_RESET_BIT]) |=>
                                 (!st.control_a_reg[B_EN] && st.run == CTC_OFF &&
                                  st.period_reg == PER_RST && st.debug_control == $past(st.debug_control)))
    else $error("soft reset incomplete");

  presc_bound_a: assert property ((running && !evmode) |-> (st.presc <= lim))
    else $error("prescaler past its division");

  enable_start_a: assert property ((ctrl_wr && pwdata[B_EN] && !pwdata[B_SOFT_RESET_BIT] &&
                                    !st.control_a_reg[B_EN] && !st.touched && !dir)
                                   |=> (st.run == CTC_RUN && st.count == '0))
    else $error("start did not run from zero");

  wrap_pulse_a: assert property ((wrap_go && !(ctrl_wr && pwdata[B_SOFT_RESET_BIT])) |=>
                                 (dma_req_out && ovf_event_out == $past(st.event_control[B_OVFEO])))
    else $error("wrap did not pulse request and event");

  presc_gate_a: assert property ((running && !evmode && st.presc != lim && !wrap_go &&
                                  !wr_go) |=> $stable(st.count))
    else $error("counter moved without prescaled tick");

  event_gate_a: assert property ((evmode && !tick && !wr_go) |=> $stable(st.count))
    else $error("counter moved without event tick");

  up_step_a: assert property ((tick && !wrap_go && !wr_go && !dir) |=>
                              (st.count == $past(st.count) + 1'b1))
    else $error("up count step wrong");

  down_start_a: assert property ((ctrl_wr && pwdata[B_EN] && !pwdata[B_SOFT_RESET_BIT] &&
                                  !st.control_a_reg[B_EN] && !st.touched && dir)
                                 |=> (st.run == CTC_RUN && st.count == $past(top)))
    else $error("start did not run from ceiling");

  disable_stop_a: assert property ((ctrl_wr && !pwdata[B_EN] && st.control_a_reg[B_EN]) |=>
                                   (st.run == CTC_OFF))
    else $error("disable did not stop the timer");

  flag_hold_a: assert property ((st.wrap_flag && !(wr_go && paddr == OFF_IRQ_FLAG_REG &&
                                 pwdata[B_WRAP]) && !(ctrl_wr && pwdata[B_SOFT_RESET_BIT]))
                                |=> st.wrap_flag)
    else $error("wrap flag dropped without clear");

endmodule

// ### rtl/ctc_pkg.sv
// Package: register map, field layout, reset values and state of the control timer
package ctc_pkg;

  localparam int CNT_W = 24;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PSC_W = 10;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CONTROL_A_REG = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CONTROL_B_REG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_EVENT_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FAULTA = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_FAULTB = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_WAVE_EXTENSION_CONTROL = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_DRIVER_CONTROL = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_DEBUG_CONTROL = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_WAVE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_FLAG_REG = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_PER = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_PERIOD_BUFFER_REG = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_CC0 = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_CCB0 = 8'h48;
  localparam logic [ADDR_W-1:0] OFF_LAST = 8'h54;

  // control_a_reg fields
  localparam int B_SOFT_RESET_BIT = 0;
  localparam int B_EN = 1;
  localparam int B_RUN_IN_STANDBY_BIT = 6;
  localparam int B_PSC = 8;
  localparam int B_PSYNC = 12;
  localparam int B_CAPTURE_ENABLE_BITS = 24;
  localparam logic [DATA_W-1:0] CONTROL_A_REG_WMASK = 32'h0F00_3743;
  // Bits that stay writable while enabled
  localparam logic [DATA_W-1:0] CONTROL_A_REG_FREE = 32'h0000_0043;
  localparam logic [1:0] PSYNC_GCLK = 2'h0;
  localparam logic [1:0] PSYNC_PRESC = 2'h1;

  // control_b_reg, event_control, driver_control, debug_control, wave fields
  localparam int B_DIR = 0;
  localparam int B_SINGLE_RUN_BIT = 2;
  localparam logic [DATA_W-1:0] CONTROL_B_REG_WMASK = 32'h0000_0005;
  localparam int B_CNTEV = 0;
  localparam int B_OVFEO = 8;
  localparam logic [DATA_W-1:0] EVENT_CONTROL_WMASK = 32'h0000_0101;
  localparam int B_NRE = 0;
  localparam int B_NRV = 8;
  localparam int B_NRFILT = 16;
  localparam logic [DATA_W-1:0] DRIVER_CONTROL_WMASK = 32'h0001_0F0F;
  localparam logic [DATA_W-1:0] DBG_WMASK = 32'h0000_0001;
  localparam int B_WG = 0;
  localparam logic [2:0] WG_MFRQ = 3'h1;
  localparam logic [DATA_W-1:0] WAVE_WMASK = 32'h0000_0007;

  // irq_flag_reg and status fields
  localparam int B_WRAP = 0;
  localparam int B_PERBV = 0;
  localparam int B_CCBV = 1;
  localparam int B_HALT = 8;

  localparam logic [CNT_W-1:0] PER_RST = 24'hFF_FFFF;

  typedef enum logic [1:0] {CTC_OFF, CTC_RUN, CTC_HALT} ctc_run_e;

  typedef struct packed {
    logic [DATA_W-1:0] control_a_reg;
    logic [DATA_W-1:0] control_b_reg;
    logic [DATA_W-1:0] event_control;
    logic [DATA_W-1:0] fault_a;
    logic [DATA_W-1:0] fault_b;
    logic [DATA_W-1:0] wave_extension_control;
    logic [DATA_W-1:0] driver_control;
    logic [DATA_W-1:0] debug_control;
    logic [DATA_W-1:0] wave;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] period_reg;
    logic [CNT_W-1:0] period_buffer_reg;
    logic [NUM_CH-1:0][CNT_W-1:0] cc;
    logic [NUM_CH-1:0][CNT_W-1:0] ccb;
    logic period_buffer_reg_v;
    logic [NUM_CH-1:0] ccb_v;
    logic wrap_flag;
    logic [PSC_W-1:0] presc;
    ctc_run_e run;
    logic touched;
    logic ev_s1;
    logic ev_s2;
    logic ev_s3;
    logic flt_s1;
    logic flt_s2;
    logic [NUM_CH-1:0] wave_q;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
    logic ovf_evt;
    logic dma_req;
  } ctc_state_s;

  localparam ctc_state_s CTC_RST = '{period_reg: PER_RST, period_buffer_reg: PER_RST, run: CTC_OFF, default: '0};

  // Division select 0..7 -> 1,2,4,8,16,64,256,1024; returns terminal count
  function automatic logic [PSC_W-1:0] ctc_div_limit(input logic [2:0] sel);
    case (sel)
      3'h0: ctc_div_limit = 10'h000;
      3'h1: ctc_div_limit = 10'h001;
      3'h2: ctc_div_limit = 10'h003;
      3'h3: ctc_div_limit = 10'h007;
      3'h4: ctc_div_limit = 10'h00F;
      3'h5: ctc_div_limit = 10'h03F;
      3'h6: ctc_div_limit = 10'h0FF;
      default: ctc_div_limit = 10'h3FF;
    endcase
  endfunction

  // Channel index within a block of four word registers
  function automatic logic [1:0] ctc_ch(input logic [ADDR_W-1:0] addr,
                                        input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] d;
    d = addr - base;
    ctc_ch = d[3:2];
  endfunction

endpackage

// ### verification/ctc_control_timer_tb.sv
// Self-checking testbench for the control timer counter core
`timescale 1ns/1ps
module ctc_control_timer_tb;
  import ctc_pkg::*;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic count_event_in0 = 1'b0;
  logic nr_fault_in = 1'b0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_CH-1:0] wave_out;
  logic ovf_event_out;
  logic dma_req_out;
  int num_errors = 0;
  int samples_checked = 0;
  int dma_n = 0;
  int ovf_n = 0;
  logic [31:0] seed = 32'h0000_D6D4;
  logic [31:0] rnd;

  ctc_control_timer u_ctc_control_timer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .count_event_in0(count_event_in0),
    .nr_fault_in(nr_fault_in), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wave_out(wave_out), .ovf_event_out(ovf_event_out), .dma_req_out(dma_req_out)
  );

  always #5 pclk = ~pclk;

  // Pulse counters stand in for the model's event queue
  always @(posedge pclk) begin
    if (dma_req_out === 1'b1) dma_n <= dma_n + 1;
    if (ovf_event_out === 1'b1) ovf_n <= ovf_n + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; caller stands just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    // Pready is registered, so its value at the rising edge is the one that counts
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("[ERR] pready expected 1 seen %b", pready);
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("write error", 32'h0000_0000, {31'h0, e});
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(what, exp, r);
  endtask

  // Bounded wait until the wrap pulse count reaches n
  task automatic wait_wraps(input int n);
    int i;
    for (i = 0; i < 200 && dma_n < n; i++) @(posedge pclk);
    if (dma_n < n) begin
      num_errors++;
      $display("[ERR] wrap pulses expected %0d seen %0d", n, dma_n);
      test_done();
    end
    repeat (10) @(posedge pclk);
  endtask

  // Bounded measure of clock edges from one wrap pulse to the next
  task automatic wrap_gap(output int gap);
    int i;
    gap = 1;
    for (i = 0; i < 300 && dma_req_out !== 1'b1; i++) @(posedge pclk);
    @(posedge pclk);
    for (i = 0; i < 300 && dma_req_out !== 1'b1; i++) begin
      @(posedge pclk);
      gap++;
    end
    if (dma_req_out !== 1'b1) begin
      num_errors++;
      $display("[ERR] wrap gap expected a pulse seen none");
      test_done();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic e;
    int g;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("per reset", OFF_PER, 32'h00FF_FFFF);
    rd("count reset", OFF_COUNT, 32'h0000_0000);
    apb(1'b0, 8'h58, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    $display("test reset and map done");

    // Ceiling from channel 0 in match-frequency mode, single run, up
    wr(OFF_EVENT_CONTROL, 32'h0000_0100);
    wr(OFF_WAVE, 32'h0000_0001);
    wr(OFF_CC0, 32'h0000_0003);
    wr(OFF_CCB0, 32'h0000_0007);
    rd("ccb valid", OFF_STATUS, 32'h0000_0002);
    wr(OFF_CONTROL_B_REG, 32'h0000_0004);
    wr(OFF_CONTROL_A_REG, 32'h0100_0000);
    wr(OFF_CONTROL_A_REG, 32'h0100_0002);
    wait_wraps(1);
    chk("dma pulses", 32'd1, dma_n);
    chk("ovf events", 32'd1, ovf_n);
    rd("halted status", OFF_STATUS, 32'h0000_0100);
    rd("count after wrap", OFF_COUNT, 32'h0000_0000);
    rd("wrap flag", OFF_IRQ_FLAG_REG, 32'h0000_0001);
    rd("wrap flag held", OFF_IRQ_FLAG_REG, 32'h0000_0001);
    wr(OFF_IRQ_FLAG_REG, 32'h0000_0001);
    rd("wrap flag clear", OFF_IRQ_FLAG_REG, 32'h0000_0000);
    wr(OFF_CONTROL_A_REG, 32'h0000_0000);
    $display("test up single run done");

    // Down count from ceiling, reload on bottom
    wr(OFF_WAVE, 32'h0000_0000);
    wr(OFF_PER, 32'h0000_0005);
    wr(OFF_CONTROL_B_REG, 32'h0000_0005);
    wr(OFF_PERIOD_BUFFER_REG, 32'h0000_0007);
    rd("period_buffer_reg valid", OFF_STATUS, 32'h0000_0001);
    wr(OFF_CONTROL_A_REG, 32'h0000_0002);
    wait_wraps(2);
    rd("count reloaded", OFF_COUNT, 32'h0000_0005);
    rd("per from buffer", OFF_PER, 32'h0000_0007);
    rd("down wrap flag", OFF_IRQ_FLAG_REG, 32'h0000_0001);
    wr(OFF_CONTROL_A_REG, 32'h0000_0000);
    $display("test down single run done");

    // Event ticks bypass the slowest prescaler
    wr(OFF_CONTROL_B_REG, 32'h0000_0000);
    wr(OFF_COUNT, 32'h0000_0000);
    wr(OFF_EVENT_CONTROL, 32'h0000_0001);
    wr(OFF_CONTROL_A_REG, 32'h0000_0702);
    repeat (5) begin
      count_event_in0 <= 1'b1;
      repeat (4) @(posedge pclk);
      count_event_in0 <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
    rd("event count", OFF_COUNT, 32'h0000_0005);
    $display("test event count done");

    // Protection while enabled
    wr(OFF_EVENT_CONTROL, 32'h0000_0000);
    rd("event_control kept", OFF_EVENT_CONTROL, 32'h0000_0001);
    wr(OFF_CONTROL_A_REG, 32'h0000_0302);
    rd("control_a_reg kept", OFF_CONTROL_A_REG, 32'h0000_0702);
    wr(OFF_CONTROL_A_REG, 32'h0000_0100);
    rd("control_a_reg disable", OFF_CONTROL_A_REG, 32'h0000_0700);
    $display("test protection done");

    // Direct counter write while running on the slow prescaler
    wr(OFF_EVENT_CONTROL, 32'h0000_0000);
    wr(OFF_CONTROL_A_REG, 32'h0000_0702);
    seed = xorshift(seed);
    rnd = {8'h00, seed[23:0]};
    wr(OFF_COUNT, rnd);
    rd("count written", OFF_COUNT, rnd);
    wr(OFF_CONTROL_A_REG, 32'h0000_0000);
    $display("test count write done");

    // Wrap spacing at division two in both synchronisation modes
    wr(OFF_PER, 32'h0000_0002);
    wr(OFF_COUNT, 32'h0000_0000);
    wr(OFF_CONTROL_A_REG, 32'h0000_1102);
    wrap_gap(g);
    chk("gap on prescaled tick", (2 + 1) * 2, g);
    wr(OFF_CONTROL_A_REG, 32'h0000_0000);
    wr(OFF_CONTROL_A_REG, 32'h0000_0102);
    wrap_gap(g);
    chk("gap on next clock", 2 * 2 + 1, g);
    wr(OFF_CONTROL_A_REG, 32'h0000_0000);
    $display("test prescaler sync done");

    // Unfiltered fault forces outputs without waiting for a clock
    wr(OFF_DRIVER_CONTROL, 32'h0000_050F);
    nr_fault_in <= 1'b1;
    @(negedge pclk);
    chk("fault outputs", 32'h5, {28'h0, wave_out});
    @(posedge pclk);
    nr_fault_in <= 1'b0;
    @(negedge pclk);
    // Count is at most two, channel 0 compares against seven, others zero
    chk("wave after fault", 32'h1, {28'h0, wave_out});
    @(posedge pclk);
    $display("test fault done");

    // Soft reset keeps debug control only
    wr(OFF_DEBUG_CONTROL, 32'h0000_0001);
    wr(OFF_CONTROL_A_REG, 32'h0000_0001);
    rd("per after soft reset", OFF_PER, 32'h00FF_FFFF);
    rd("dbg kept", OFF_DEBUG_CONTROL, 32'h0000_0001);
    rd("control_a_reg after soft reset", OFF_CONTROL_A_REG, 32'h0000_0000);
    $display("test soft reset done");
    test_done();
  end

endmodule
